// ==== common/dcr_pkg.sv ====
/*
  Shared constants for the acquisition card I/O register bank: the byte offsets
  within the 16-byte window, field positions, reset values and mode encodings.
  Assumes a byte-wide host bus that presents the low four address bits.
*/
package dcr_pkg;

  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned ADC_W     = 16;
  localparam int unsigned DAC_W     = 12;
  localparam int unsigned DIO_W     = 16;
  localparam int unsigned DAC_CHANS = 2;
  localparam int unsigned SYNC_W    = DIO_W + 2;

  // Byte offsets from the base address.
  localparam logic [ADDR_W-1:0] OFF_TIMER_COUNT_ZERO = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_TIMER_COUNT_ONE  = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_TIMER_COUNT_TWO  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL    = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_OUT1_DATA_LOW    = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_OUT1_DATA_HIGH   = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_CONV_DATA_LOW    = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_CONV_DATA_HIGH   = 4'h5;
  localparam logic [ADDR_W-1:0] OFF_INPUT_LINES_LOW  = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_INPUT_LINES_HIGH = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_OUT2_DATA_LOW    = 4'h6;
  localparam logic [ADDR_W-1:0] OFF_OUT2_DATA_HIGH   = 4'h7;
  localparam logic [ADDR_W-1:0] OFF_IRQ_FLAG_CLEAR   = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_STATUS           = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_GAIN_SELECT      = 4'h9;
  localparam logic [ADDR_W-1:0] OFF_INPUT_SELECTOR   = 4'ha;
  localparam logic [ADDR_W-1:0] OFF_TRIGGER_MODE     = 4'hb;
  localparam logic [ADDR_W-1:0] OFF_CONVERSION_KICK  = 4'hc;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_LINES_LOW = 4'hd;
  localparam logic [ADDR_W-1:0] OFF_OUTPUT_LINES_HI  = 4'he;

  // Field positions.
  localparam int unsigned SEL_CHAN_LSB   = 0;
  localparam int unsigned SEL_CHAN_MSB   = 3;
  localparam int unsigned SEL_LOWER_BIT  = 4;
  localparam int unsigned SEL_UPPER_BIT  = 5;
  localparam int unsigned GAIN_LSB       = 0;
  localparam int unsigned GAIN_MSB       = 1;
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned MODE_MSB       = 2;
  localparam int unsigned STAT_READY_BIT = 5;
  localparam int unsigned DAC_HI_MSB     = 3;

  // Reset values.
  localparam logic [3:0]        RST_CHAN     = 4'h0;
  localparam logic [1:0]        RST_GAIN     = 2'h0;
  localparam logic [2:0]        RST_MODE     = 3'h1;
  localparam logic [BYTE_W-1:0] RST_BYTE     = 8'h00;
  localparam logic [DIO_W-1:0]  RST_DIO      = 16'h0000;
  localparam logic [ADC_W-1:0]  RST_ADC      = 16'h0000;
  localparam logic [DAC_W-1:0]  RST_DAC      = 12'h000;

  typedef enum logic [2:0] {
    MODE_OFF       = 3'b000,
    MODE_SW_POLL   = 3'b001,
    MODE_PACER_DMA = 3'b010,
    MODE_PACER_IRQ = 3'b110
  } dcr_mode_t;

endpackage : dcr_pkg

// ==== logic/dcr_register_bank.sv ====
/*
  Host-facing I/O register bank of the acquisition card: input selector, gain,
  trigger and transfer mode, interrupt flag, conversion kick, digital lines,
  two double-buffered output channels and the window onto the interval timer.
  Assumes host strobes are one-cycle pulses on i_core_clk, the timer answers
  reads combinationally, and the converter reports completion with a pulse.
*/
// Functional notes
// - Selector write switches the multiplexer to the new channel at once.
// - Selector bit 4 alone picks inputs 0-7, bit 5 alone picks 8-15.
// - Both bank bits set means eight differential channel pairs.
// - Channel field is bits 3:0; bits 7:6 are ignored.
// - Gain bits 1:0 at offset nine pick gain 1, 2, 4 or 8.
// - Mode bits 2:0 at offset eleven pick the trigger and transfer mode.
// - Mode zero ignores software and pacer triggers.
// - After reset the mode is software trigger with polling.
// - External trigger is accepted in any mode when the jumper selects it.
// - Outside DMA mode, converted data and ready bit stay pollable.
// - Pacer interrupt mode raises an interrupt at each conversion end.
// - Interrupt flag set per conversion; no new interrupt until cleared.
// - Any write to offset eight clears the interrupt flag, unless a conversion end in interrupt mode sets it in the same cycle.
// - In software-trigger mode with the jumper on internal, any write to offset twelve issues one conversion start pulse.
// - Offsets six and seven read input lines 7..0 and 15..8.
// - Offsets thirteen and fourteen drive output lines 7..0 and 15..8.
// - First output: offset four low byte, offset five low nibble high.
// - Second output uses offsets six and seven in the same layout.
// - Output value is 12 bits, LSB bit 0 low, MSB bit 3 high.
// - Low byte is held; all 12 bits update on the high byte write.
// - Offsets zero to three reach the three counters and timer control; timer control at offset three is write-only and reads as zero.
// - Two cascaded counters pace conversions; the third is free.
// - Status bit 5 is one while not ready, zero when done.
// - Converted 16-bit value reads low at four, high at five.
// - Counters one and two cascade to form the pacer tick.
`timescale 1ns/100ps

module dcr_register_bank
  import dcr_pkg::*;
#(
  parameter int unsigned P_ADC_W = ADC_W,
  parameter int unsigned P_DIO_W = DIO_W
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_nrst,
  input  wire logic [ADDR_W-1:0]   i_addr,
  input  wire logic                i_wr_en,
  input  wire logic                i_rd_en,
  input  wire logic [BYTE_W-1:0]   i_wdata,
  output logic      [BYTE_W-1:0]   o_rdata,
  output logic                     o_rd_valid,
  output logic      [1:0]          o_timer_addr,
  output logic                     o_timer_wr_en,
  output logic                     o_timer_rd_en,
  output logic      [BYTE_W-1:0]   o_timer_wdata,
  input  wire logic [BYTE_W-1:0]   i_timer_rdata,
  input  wire logic                i_pacer_tick,
  output logic                     o_conv_start,
  input  wire logic                i_conv_done,
  input  wire logic [P_ADC_W-1:0]  i_conv_data,
  output logic      [3:0]          o_mux_chan,
  output logic                     o_lower_bank_select,
  output logic                     o_upper_bank_select,
  output logic                     o_diff_mode,
  output logic      [1:0]          o_gain,
  output logic      [2:0]          o_mode,
  output logic                     o_irq,
  output logic                     o_dma_req,
  input  wire logic [P_DIO_W-1:0]  i_input_line,
  output logic      [P_DIO_W-1:0]  o_output_line,
  input  wire logic                i_trigger_source_jumper,
  input  wire logic                i_outside_trigger_in,
  output logic      [DAC_W-1:0]    o_out1_value,
  output logic      [DAC_W-1:0]    o_out2_value
);

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  localparam int unsigned SW = P_DIO_W + 2;

  logic [SW-1:0] pin_raw;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic [SW-1:0] sync3_q;
  logic [SW-1:0] pin_filt_q;
  logic [SW-1:0] pin_filt_d;

  assign pin_raw = {i_outside_trigger_in, i_trigger_source_jumper, i_input_line};

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A bit only moves once two settled stages agree, which masks a late glitch.
  assign pin_filt_d = (sync2_q & ~(sync2_q ^ sync3_q)) | (pin_filt_q & (sync2_q ^ sync3_q));

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_filt_q <= '0;
    end else begin
      pin_filt_q <= pin_filt_d;
    end
  end

  logic [P_DIO_W-1:0] in_lines;
  logic               jumper_ext;
  logic               ext_trig_lvl;
  logic               ext_trig_prev_q;
  logic               ext_rise;

  assign in_lines     = pin_filt_q[P_DIO_W-1:0];
  assign jumper_ext   = pin_filt_q[P_DIO_W];
  assign ext_trig_lvl = pin_filt_q[P_DIO_W+1];
  assign ext_rise     = ext_trig_lvl && !ext_trig_prev_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_trig_prev_q <= 1'b0;
    end else begin
      ext_trig_prev_q <= ext_trig_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.

  function automatic logic wr_hit(input logic [ADDR_W-1:0] off);
    return i_wr_en && (i_addr == off);
  endfunction : wr_hit

  logic timer_hit;
  assign timer_hit = (i_addr <= OFF_TIMER_CONTROL);

  assign o_timer_addr  = i_addr[1:0];
  assign o_timer_wr_en = i_wr_en && timer_hit;
  assign o_timer_rd_en = i_rd_en && (i_addr < OFF_TIMER_CONTROL);
  assign o_timer_wdata = i_wdata;

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  logic [3:0] chan_q;
  logic       lower_q;
  logic       upper_q;
  logic [1:0] gain_q;
  logic [2:0] mode_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chan_q  <= RST_CHAN;
      lower_q <= 1'b0;
      upper_q <= 1'b0;
    end else if (wr_hit(OFF_INPUT_SELECTOR)) begin
      chan_q  <= i_wdata[SEL_CHAN_MSB:SEL_CHAN_LSB];
      lower_q <= i_wdata[SEL_LOWER_BIT];
      upper_q <= i_wdata[SEL_UPPER_BIT];
    end
  end

  assign o_lower_bank_select = lower_q;
  assign o_upper_bank_select = upper_q;
  assign o_diff_mode = lower_q && upper_q;
  assign o_mux_chan = chan_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gain_q <= RST_GAIN;
    end else if (wr_hit(OFF_GAIN_SELECT)) begin
      gain_q <= i_wdata[GAIN_MSB:GAIN_LSB];
    end
  end
  assign o_gain = gain_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_q <= RST_MODE;
    end else if (wr_hit(OFF_TRIGGER_MODE)) begin
      mode_q <= i_wdata[MODE_MSB:MODE_LSB];
    end
  end
  assign o_mode = mode_q;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection.

  logic mode_sw;
  logic mode_dma;
  logic mode_irq;
  logic conv_start_d;
  logic conv_start_q;

  assign mode_sw  = (mode_q == MODE_SW_POLL);
  assign mode_dma = (mode_q == MODE_PACER_DMA);
  assign mode_irq = (mode_q == MODE_PACER_IRQ);

  always_comb begin
    conv_start_d = 1'b0;
    if (jumper_ext) begin
      conv_start_d = ext_rise;
    end else begin
      // internal sources off in mode zero and unlisted codes
      case (mode_q)
        MODE_SW_POLL:   conv_start_d = wr_hit(OFF_CONVERSION_KICK);
        MODE_PACER_DMA: conv_start_d = i_pacer_tick;
        MODE_PACER_IRQ: conv_start_d = i_pacer_tick;
        default:        conv_start_d = 1'b0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_start_q <= 1'b0;
    end else begin
      conv_start_q <= conv_start_d;
    end
  end
  assign o_conv_start = conv_start_q;

  ////////////////////////////////////////////////////////////////////////////
  // Converted data, ready bit, interrupt and DMA request.

  logic [P_ADC_W-1:0] conv_data_q;
  logic               not_ready_q;
  logic               irq_flag_q;
  logic               dma_req_q;
  logic               low_read;
  logic               irq_clear;

  assign low_read  = i_rd_en && (i_addr == OFF_CONV_DATA_LOW);
  assign irq_clear = wr_hit(OFF_IRQ_FLAG_CLEAR);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_data_q <= '0;
    end else if (i_conv_done) begin
      conv_data_q <= i_conv_data;
    end
  end

  // ready bit, completion wins over a coincident low-byte read
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      not_ready_q <= 1'b1;
    end else if (i_conv_done) begin
      not_ready_q <= 1'b0;
    end else if (low_read || conv_start_q) begin
      not_ready_q <= 1'b1;
    end
  end

  // sticky flag, a new conversion end wins over the clear
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_flag_q <= 1'b0;
    end else if (i_conv_done && mode_irq) begin
      irq_flag_q <= 1'b1;
    end else if (irq_clear) begin
      irq_flag_q <= 1'b0;
    end
  end
  assign o_irq = irq_flag_q;

  // only DMA mode raises a transfer request
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      dma_req_q <= 1'b0;
    end else if (i_conv_done && mode_dma) begin
      dma_req_q <= 1'b1;
    end else if (low_read) begin
      dma_req_q <= 1'b0;
    end
  end
  assign o_dma_req = dma_req_q;

  ////////////////////////////////////////////////////////////////////////////
  // Digital outputs.

  logic [P_DIO_W-1:0] out_lines_q;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_lines_q <= RST_DIO;
    end else begin
      if (wr_hit(OFF_OUTPUT_LINES_LOW)) begin
        out_lines_q[7:0] <= i_wdata;
      end
      if (wr_hit(OFF_OUTPUT_LINES_HI)) begin
        out_lines_q[15:8] <= i_wdata;
      end
    end
  end
  assign o_output_line = out_lines_q;

  ////////////////////////////////////////////////////////////////////////////
  // Double-buffered output channels.

  logic [BYTE_W-1:0] dac_low_q [DAC_CHANS];
  logic [DAC_W-1:0]  dac_val_q [DAC_CHANS];

  for (genvar g = 0; g < DAC_CHANS; g++) begin : g_dac
    localparam logic [ADDR_W-1:0] LOW_OFF  = ADDR_W'(OFF_OUT1_DATA_LOW + 2 * g);
    localparam logic [ADDR_W-1:0] HIGH_OFF = ADDR_W'(OFF_OUT1_DATA_HIGH + 2 * g);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        dac_low_q[g] <= RST_BYTE;
      end else if (wr_hit(LOW_OFF)) begin
        dac_low_q[g] <= i_wdata;
      end
    end

    // load all bits on high write
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        dac_val_q[g] <= RST_DAC;
      end else if (wr_hit(HIGH_OFF)) begin
        dac_val_q[g] <= {i_wdata[DAC_HI_MSB:0], dac_low_q[g]};
      end
    end
  end

  assign o_out1_value = dac_val_q[0];
  assign o_out2_value = dac_val_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Read path.

  logic [BYTE_W-1:0] rdata_d;
  logic [BYTE_W-1:0] rdata_q;
  logic              rd_valid_q;

  always_comb begin
    rdata_d = RST_BYTE;
    case (i_addr)
      OFF_TIMER_COUNT_ZERO: rdata_d = i_timer_rdata;
      OFF_TIMER_COUNT_ONE:  rdata_d = i_timer_rdata;
      OFF_TIMER_COUNT_TWO:  rdata_d = i_timer_rdata;
      OFF_CONV_DATA_LOW:    rdata_d = conv_data_q[7:0];
      OFF_CONV_DATA_HIGH:   rdata_d = conv_data_q[15:8];
      OFF_INPUT_LINES_LOW:  rdata_d = in_lines[7:0];
      OFF_INPUT_LINES_HIGH: rdata_d = in_lines[15:8];
      OFF_STATUS:           rdata_d[STAT_READY_BIT] = not_ready_q;
      default:              rdata_d = RST_BYTE;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q    <= RST_BYTE;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= i_rd_en;
      if (i_rd_en) begin
        rdata_q <= rdata_d;
      end
    end
  end
  assign o_rdata    = rdata_q;
  assign o_rd_valid = rd_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_wr(logic [ADDR_W-1:0] off);
    i_wr_en && (i_addr == off);
  endsequence

  sequence s_pulse_once;
    o_conv_start ##1 !o_conv_start;
  endsequence

  mux_update_a: assert property (s_wr(OFF_INPUT_SELECTOR) |=>
    o_mux_chan == $past(i_wdata[3:0])) else $error("selector channel not updated");
  bank_decode_a: assert property (s_wr(OFF_INPUT_SELECTOR) |=>
    o_diff_mode == ($past(i_wdata[5]) && $past(i_wdata[4]))) else $error("differential decode wrong");
  gain_write_a: assert property (s_wr(OFF_GAIN_SELECT) |=>
    o_gain == $past(i_wdata[1:0])) else $error("gain not updated");
  mode_off_a: assert property (mode_q == MODE_OFF && !jumper_ext |=>
    !o_conv_start) else $error("internal trigger in disabled mode");
  kick_pulse_a: assert property (s_wr(OFF_CONVERSION_KICK) && mode_sw && !jumper_ext |=>
    s_pulse_once) else $error("software kick pulse wrong");
  ext_trig_a: assert property (jumper_ext && ext_rise |=>
    o_conv_start) else $error("external trigger lost");
  irq_hold_a: assert property (o_irq && !(i_wr_en && (i_addr == OFF_IRQ_FLAG_CLEAR)) |=>
    o_irq) else $error("interrupt dropped before clear");
  irq_clear_a: assert property (s_wr(OFF_IRQ_FLAG_CLEAR) && !(i_conv_done && mode_irq) |=>
    !o_irq) else $error("interrupt flag not cleared");
  irq_raise_a: assert property (i_conv_done && mode_irq |=>
    o_irq) else $error("no interrupt at conversion end");
  ready_bit_a: assert property (i_conv_done |=>
    !not_ready_q) else $error("ready bit not cleared at completion");
  dac_hold_a: assert property (s_wr(OFF_OUT1_DATA_LOW) |=>
    $stable(o_out1_value)) else $error("output moved on low byte");
  dac_load_a: assert property (s_wr(OFF_OUT2_DATA_HIGH) |=>
    o_out2_value == {$past(i_wdata[3:0]), $past(dac_low_q[1])}) else $error("output value assembly wrong");
  dout_a: assert property (s_wr(OFF_OUTPUT_LINES_HI) ##1 1'b1 |->
    o_output_line[15:8] == $past(i_wdata)) else $error("output lines high byte wrong");

endmodule : dcr_register_bank

// ==== verif/dcr_host_model.sv ====
/*
  Host processor model: byte writes and reads into the card's 16-byte window.
  Assumes the bank takes one-cycle strobes and answers reads within 4 cycles.
*/
`timescale 1ns/100ps

module dcr_host_model
  import dcr_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic [BYTE_W-1:0] i_rdata,
  input  wire logic              i_rd_valid,
  output logic      [ADDR_W-1:0] o_addr,
  output logic                   o_wr_en,
  output logic                   o_rd_en,
  output logic      [BYTE_W-1:0] o_wdata
);
  initial begin
    o_addr  = '0;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_wdata = '0;
  end

  // Data is inverted once released, so a stale byte can never pass as valid.
  task automatic bus_write(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr_en <= 1'b1;
    @(posedge i_clk);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
  endtask : bus_write

  task automatic bus_read(input logic [ADDR_W-1:0] a, output logic [BYTE_W-1:0] d, output logic ok);
    ok = 1'b0;
    d  = '0;
    @(posedge i_clk);
    o_addr  <= a;
    o_rd_en <= 1'b1;
    @(posedge i_clk);
    o_rd_en <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge i_clk);
      if (i_rd_valid === 1'b1) begin
        ok = 1'b1;
        d  = i_rdata;
      end
    end
  endtask : bus_read
endmodule : dcr_host_model

// ==== verif/tb.sv ====
/*
  Self-checking bench for the register bank: scenario tasks drive the host
  model, converter, pacer and pins, then compare the bank's outputs.
  Assumes one 200 MHz clock and the constants of the shared package.
*/
`timescale 1ns/100ps

module tb
  import dcr_pkg::*;
;
  logic        clk, nrst, wr_en, rd_en, rd_valid, pacer_tick, conv_start, conv_done;
  logic        lower, upper, diff, irq, dma_req, jumper, ext_trig;
  logic [3:0]  addr, mux_chan;
  logic [7:0]  wdata, rdata, timer_rdata;
  logic [1:0]  gain;
  logic [2:0]  mode;
  logic [15:0] conv_data, in_line, out_line;
  logic [11:0] out1, out2;
  logic [1:0]  timer_addr;
  logic [7:0]  timer_wdata;
  logic        timer_wr, timer_rd;
  logic [9:0]  timer_last = '0;
  int          n_timer_wr = 0;
  int          n_timer_rd = 0;
  int          n_fail  = 0;
  int          checked = 0;

  dcr_host_model i_host (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_addr(addr),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_wdata(wdata));

  dcr_register_bank i_dut (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wr_en(wr_en),
    .i_rd_en(rd_en), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid), .o_timer_addr(timer_addr),
    .o_timer_wr_en(timer_wr), .o_timer_rd_en(timer_rd), .o_timer_wdata(timer_wdata), .i_timer_rdata(timer_rdata),
    .i_pacer_tick(pacer_tick), .o_conv_start(conv_start), .i_conv_done(conv_done),
    .i_conv_data(conv_data), .o_mux_chan(mux_chan), .o_lower_bank_select(lower),
    .o_upper_bank_select(upper), .o_diff_mode(diff), .o_gain(gain), .o_mode(mode), .o_irq(irq),
    .o_dma_req(dma_req), .i_input_line(in_line), .o_output_line(out_line),
    .i_trigger_source_jumper(jumper), .i_outside_trigger_in(ext_trig), .o_out1_value(out1),
    .o_out2_value(out2));

  // Timer strobes are counted at the edge that takes them, as the timer itself would see them.
  always @(posedge clk) begin
    if (timer_wr === 1'b1) begin
      n_timer_wr++;
      timer_last = {timer_addr, timer_wdata};
    end
    if (timer_rd === 1'b1) begin
      n_timer_rd++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.bus_write(a, d);
  endtask : wr

  // A read that never answers ends the run at once.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    logic ok;
    i_host.bus_read(a, d, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
  endtask : rd

  task automatic rdc(input logic [3:0] a, input logic [7:0] e, input string m);
    logic [7:0] d;
    rd(a, d);
    chk(16'(d), 16'(e), m);
  endtask : rdc

  task automatic starts(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(negedge clk);
      if (conv_start === 1'b1) c++;
    end
  endtask : starts

  task automatic conv(input logic [15:0] v);
    @(posedge clk);
    conv_data <= v;
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
    conv_data <= ~v;
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] d;
    chk(16'(mode), 16'(MODE_SW_POLL), "mode");
    rd(OFF_STATUS, d);
    chk(16'(d[STAT_READY_BIT]), 16'h1, "ready");
  endtask : t_reset

  task automatic t_sel_gain();
    logic [7:0] v [3] = '{8'hd3, 8'h2b, 8'h35};
    foreach (v[i]) begin
      wr(OFF_INPUT_SELECTOR, v[i]);
      @(negedge clk);
      chk(16'(mux_chan), 16'(v[i][3:0]), "chan");
      chk(16'({upper, lower}), 16'(v[i][5:4]), "bank");
      chk(16'(diff), 16'(&v[i][5:4]), "diff");
    end
    for (int g = 0; g < 4; g++) begin
      wr(OFF_GAIN_SELECT, 8'(g) | 8'hfc);
      @(negedge clk);
      chk(16'(gain), 16'(g), "gain");
    end
  endtask : t_sel_gain

  task automatic t_trig();
    logic [2:0] m [4] = '{3'b000, 3'b001, 3'b010, 3'b110};
    int c;
    foreach (m[i]) begin
      wr(OFF_TRIGGER_MODE, {5'h1f, m[i]});
      @(negedge clk);
      chk(16'(mode), 16'(m[i]), "mode");
      wr(OFF_CONVERSION_KICK, 8'hff);
      starts(4, c);
      chk(16'(c), 16'(m[i] == 3'b001), "kick");
      @(posedge clk) pacer_tick <= 1'b1;
      @(posedge clk) pacer_tick <= 1'b0;
      starts(4, c);
      chk(16'(c), 16'(m[i][1]), "pacer");
    end
  endtask : t_trig

  task automatic t_conv();
    logic [7:0] d;
    wr(OFF_TRIGGER_MODE, 8'h06);
    conv(16'h8001);
    @(negedge clk);
    chk(16'(irq), 16'h1, "irq");
    rd(OFF_STATUS, d);
    chk(16'(d[STAT_READY_BIT]), 16'h0, "done");
    conv(16'h1234);
    repeat (3) @(negedge clk);
    chk(16'(irq), 16'h1, "irq hold");
    wr(OFF_IRQ_FLAG_CLEAR, 8'h5a);
    @(negedge clk);
    chk(16'(irq), 16'h0, "irq clear");
    rdc(OFF_CONV_DATA_LOW, 8'h34, "ad lo");
    rdc(OFF_CONV_DATA_HIGH, 8'h12, "ad hi");
    rd(OFF_STATUS, d);
    chk(16'(d[STAT_READY_BIT]), 16'h1, "read low");
    wr(OFF_TRIGGER_MODE, 8'h01);
    conv(16'h00ff);
    @(negedge clk);
    chk(16'(irq), 16'h0, "irq poll");
    wr(OFF_TRIGGER_MODE, 8'h02);
    conv(16'h0102);
    @(negedge clk);
    chk(16'(dma_req), 16'h1, "dma");
    rdc(OFF_CONV_DATA_LOW, 8'h02, "dma lo");
    chk(16'(dma_req), 16'h0, "dma done");
  endtask : t_conv

  task automatic t_lines();
    @(posedge clk) in_line <= 16'hc35a;
    repeat (6) @(posedge clk);
    rdc(OFF_INPUT_LINES_LOW, 8'h5a, "in lo");
    rdc(OFF_INPUT_LINES_HIGH, 8'hc3, "in hi");
    wr(OFF_OUTPUT_LINES_LOW, 8'ha5);
    wr(OFF_OUTPUT_LINES_HI, 8'h3c);
    @(negedge clk);
    chk(out_line, 16'h3ca5, "out lines");
    wr(OFF_OUT1_DATA_LOW, 8'h9c);
    wr(OFF_OUT1_DATA_HIGH, 8'hf7);
    @(negedge clk);
    chk(16'(out1), 16'h079c, "out1");
    wr(OFF_OUT1_DATA_LOW, 8'h21);
    wr(OFF_OUT2_DATA_LOW, 8'h4e);
    wr(OFF_OUT2_DATA_HIGH, 8'h8a);
    @(negedge clk);
    chk(16'(out1), 16'h079c, "out1 held");
    chk(16'(out2), 16'h0a4e, "out2");
    wr(OFF_OUT1_DATA_HIGH, 8'h03);
    @(negedge clk);
    chk(16'(out1), 16'h0321, "out1 new");
    wr(OFF_TIMER_CONTROL, 8'h36);
    @(negedge clk);
    chk(16'(n_timer_wr), 16'h1, "timer wr");
    chk(16'(timer_last), 16'h0336, "timer ctl");
    rdc(OFF_TIMER_COUNT_TWO, 8'h6b, "timer");
    rdc(OFF_TIMER_CONTROL, 8'h00, "ctl read");
    chk(16'(n_timer_rd), 16'h1, "timer rd");
    rdc(OFF_GAIN_SELECT, 8'h00, "wo read");
    chk(16'(gain), 16'h3, "no effect");
  endtask : t_lines

  task automatic t_ext();
    int c;
    @(posedge clk) jumper <= 1'b1;
    repeat (6) @(posedge clk);
    wr(OFF_TRIGGER_MODE, 8'h00);
    wr(OFF_CONVERSION_KICK, 8'h00);
    starts(4, c);
    chk(16'(c), 16'h0, "kick off");
    @(posedge clk) ext_trig <= 1'b1;
    starts(10, c);
    chk(16'(c), 16'h1, "ext");
    @(posedge clk) ext_trig <= 1'b0;
  endtask : t_ext

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    nrst        = 1'b0;
    pacer_tick  = 1'b0;
    conv_done   = 1'b0;
    conv_data   = 16'h0000;
    in_line     = 16'h0000;
    jumper      = 1'b0;
    ext_trig    = 1'b0;
    timer_rdata = 8'h6b;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_sel_gain();
    t_trig();
    t_conv();
    t_lines();
    t_ext();
    print_verdict();
  end
endmodule : tb
